// ===== rtl/dsp_interrupt_and_low_power.sv
/*
   Interrupt controller and low-power control: latches, masks, ranks and
   vectors eleven sources, keeps a status stack, runs idle, slow idle and
   power-down sequencing. Registers sit on a classic Wishbone slave.
   Assumes pins are synchronous to clk_i and clk_i is the processor cycle.
*/
// How it works
// - eleven sources plus reset, fixed ranking, all maskable except power-down.
// - four active-low pins: configurable, two level, one edge on flag pins.
// - port-one reconfig turns its pins into two more irqs and flag in/out.
// - three configurable pins pick edge or level; others are fixed sense.
// - vectors: reset 0000, power-down 002c, then 0004..0028 by rank.
// - pending AND mask, highest surviving request is chosen.
// - control register picks nested or sequential and holds sense bits.
// - mask write blocks all interrupts for one instruction cycle.
// - write-only force/clear register sets or clears pending requests.
// - twelve-deep status stack saved on entry, restored on return.
// - global enable/disable gates every interrupt including power-down.
// - global enable is on after reset.
// - power-down pin or force bit raises edge interrupt; entry comes later.
// - wake after 200 input clocks, or 4096 when oscillator stopped.
// - context bit picks resume or clean restart after power-down.
// - reset ends power-down.
// - acknowledge output shows that power-down was entered.
// - idle halts until an unmasked interrupt, then services and continues.
// - slow idle divides cycle rate by 16, 32, 64 or 128; none is idle.
// - slow idle may hold up to divisor cycles after an interrupt.
// - shared pins act as flag and interrupt at once.
`timescale 1ns/100ps
`include "dsp_irq_defines.svh"

module dsp_interrupt_and_low_power
   import dsp_irq_pkg::*;
#(
   parameter int WAKE_RUN_CYCLES = `WAKE_RUN_INPUT_CLOCK * `INPUT_CLOCK_PER_CYC,
   parameter int WAKE_OSC_CYCLES = `WAKE_OSC_INPUT_CLOCK * `INPUT_CLOCK_PER_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // external pins; irq and power-down request inputs active low, flags and ack active high
   input  wire logic        ext_irq_cfg_a_n_i,
   input  wire logic        ext_level_irq_0_n_i,
   input  wire logic        ext_level_irq_1_n_i,
   input  wire logic        ext_edge_irq_n_i,
   input  wire logic        port1_alt_irq_0_n_i,
   input  wire logic        port1_alt_irq_1_n_i,
   input  wire logic        port1_flag_in_i,
   output logic             port1_flag_out_o,
   input  wire logic        power_down_request_pin_n_i,
   output logic             power_down_ack_o,
   // internal event pulses
   input  wire logic        port0_tx_i,
   input  wire logic        port0_rx_i,
   input  wire logic        port1_tx_i,
   input  wire logic        port1_rx_i,
   input  wire logic        byte_dma_port_i,
   input  wire logic        timer_i,
   // sequencer side
   input  wire logic        ret_i,
   input  wire logic        push_i,
   input  wire logic        pop_i,
   input  wire logic [15:0] status_i,
   output logic      [15:0] status_o,
   output logic             int_take_o,
   output logic      [13:0] int_vector_o,
   output logic             halt_o,
   output logic             cycle_en_o,
   output logic             context_clear_o
);

   // ==========================================================
   // helpers
   function automatic src_idx_t first_idx(input logic [`NSRC-1:0] v);
      first_idx = 4'hf;
      for (int i = `NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_idx = src_idx_t'(i);
         end
      end
   endfunction : first_idx

   function automatic logic [`NSRC-1:0] one_hot(input src_idx_t idx);
      one_hot = '0;
      if (idx < 4'(`NSRC)) begin
         one_hot[idx] = 1'b1;
      end
   endfunction : one_hot

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0]  sel);
      merge16 = old;
      if (sel[0]) begin
         merge16[7:0] = din[7:0];
      end
      if (sel[1]) begin
         merge16[15:8] = din[15:8];
      end
   endfunction : merge16

   // ==========================================================
   // reset release
   logic rst_meta_reg;
   logic rst_n;

   // release through two flops so every flop leaves reset on one edge
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // ==========================================================
   // state declarations
   logic [`NMASK-1:0] mask_reg;
   logic [`CTL_W-1:0] ctrl_reg;
   logic [`NSRC-1:0]  latch_reg;
   logic [`NSRC-1:0]  prev_reg;
   logic [`NSRC-1:0]  svc_reg;
   logic              gie_reg;
   logic              blk_reg;
   lp_state_t         state_reg;
   logic [7:0]        div_cnt_reg;
   logic [7:0]        div_lim_reg;
   logic [15:0]       wake_cnt_reg;
   logic [3:0]        sp_reg;
   logic              ovf_reg;
   logic [15:0]       stack_mem [`STACK_DEPTH];

   // ==========================================================
   // bus decode
   logic        wr_req;
   logic [15:0] fc_force;
   logic [15:0] fc_clear;
   logic        cmd_wr;

   // a request is taken once, on the edge that raises ack
   assign wr_req   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign cmd_wr   = wr_req & (wb_adr_i == `OFS_CMD);
   assign fc_force = (wr_req && wb_adr_i == `OFS_FORCE) ? merge16('0, wb_dat_i, wb_sel_i) : '0;
   assign fc_clear = (wr_req && wb_adr_i == `OFS_FORCE) ? merge16('0, wb_dat_i >> `FC_CLR_LSB, wb_sel_i >> 2) : '0;

   // ==========================================================
   // source levels and sense
   logic [`NSRC-1:0] act;
   logic [`NSRC-1:0] edge_sel;
   logic             p1_irq;

   assign p1_irq = ctrl_reg[`CTL_PORT1_IRQ];

   // shared pins are read as resolved levels, so a flag set by software also fires
   always_comb begin
      act                = '0;
      act[`SRC_PWD]      = ~power_down_request_pin_n_i;
      act[`SRC_CFG_A]    = ~ext_irq_cfg_a_n_i;
      act[`SRC_LVL1]     = ~ext_level_irq_1_n_i;
      act[`SRC_LVL0]     = ~ext_level_irq_0_n_i;
      act[`SRC_P0_TX]    = port0_tx_i;
      act[`SRC_P0_RX]    = port0_rx_i;
      act[`SRC_EDGE]     = ~ext_edge_irq_n_i;
      act[`SRC_BYTE_DMA_PORT]     = byte_dma_port_i;
      act[`SRC_P1_TX]    = p1_irq ? ~port1_alt_irq_1_n_i : port1_tx_i;
      act[`SRC_P1_RX]    = p1_irq ? ~port1_alt_irq_0_n_i : port1_rx_i;
      act[`SRC_TIMER]    = timer_i;
   end

   // internal pulses count as edges; only three pins have a choice
   always_comb begin
      edge_sel             = '1;
      edge_sel[`SRC_CFG_A] = ctrl_reg[`CTL_EDGE_CFG_A];
      edge_sel[`SRC_LVL1]  = 1'b0;
      edge_sel[`SRC_LVL0]  = 1'b0;
      edge_sel[`SRC_P1_TX] = ~p1_irq | ctrl_reg[`CTL_EDGE_ALT1];
      edge_sel[`SRC_P1_RX] = ~p1_irq | ctrl_reg[`CTL_EDGE_ALT0];
   end

   // ==========================================================
   // pending, masking, priority
   logic [`NSRC-1:0] set_evt;
   logic [`NSRC-1:0] pending;
   logic [`NSRC-1:0] cand;
   src_idx_t         sel_idx;
   src_idx_t         svc_top;
   logic             allow;
   logic             want;
   logic             take;
   logic             ret;

   // while powered down the pin edge only wakes the core, it must not also latch a request
   logic [`NSRC-1:0] pd_hold;
   assign pd_hold = (state_reg == ST_PD || state_reg == ST_WAKE) ? one_hot(4'(`SRC_PWD)) : '0;
   // a level source is pending only while held; only a force write latches it
   assign set_evt = (edge_sel & act & ~prev_reg & ~pd_hold)
                  | fc_force[`NSRC-1:0];
   assign pending = latch_reg | (~edge_sel & act);
   assign cand    = pending & {mask_reg, 1'b1} & {`NSRC{gie_reg & ~blk_reg}};
   assign sel_idx = first_idx(cand);
   assign svc_top = first_idx(svc_reg);
   // nested lets a higher rank cut in; sequential waits for the return
   assign allow   = (svc_reg == '0) | (ctrl_reg[`CTL_NEST] & (sel_idx < svc_top));
   assign want    = (cand != '0) & allow;
   assign take    = want & cycle_en_o & (state_reg == ST_RUN);
   assign ret     = ret_i | (cmd_wr & wb_sel_i[0] & wb_dat_i[`CMD_RTI]);

   // previous pin levels for edge detection
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= '1;
      end else begin
         prev_reg <= act;
      end
   end

   // latched requests; a new event wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         latch_reg <= '0;
      end else begin
         latch_reg <= (latch_reg & ~fc_clear[`NSRC-1:0] & ~(take ? one_hot(sel_idx) : '0)) | set_evt;
      end
   end

   // in-service levels drive the nesting decision
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         svc_reg <= '0;
      end else if (state_reg == ST_WAKE && wake_cnt_reg == '0 && ctrl_reg[`CTL_POWER_UP_CONTEXT_RESET]) begin
         svc_reg <= '0;
      end else begin
         svc_reg <= (svc_reg & ~(ret ? one_hot(svc_top) : '0)) | (take ? one_hot(sel_idx) : '0);
      end
   end

   // ==========================================================
   // mask, control, global enable
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= `MASK_RST;
         ctrl_reg <= `CTRL_RST;
      end else if (wr_req && wb_adr_i == `OFS_MASK) begin
         mask_reg <= `NMASK'(merge16(16'(mask_reg), wb_dat_i, wb_sel_i));
      end else if (wr_req && wb_adr_i == `OFS_CTRL) begin
         ctrl_reg <= `CTL_W'(merge16(16'(ctrl_reg), wb_dat_i, wb_sel_i));
      end
   end

   // one instruction cycle of blocking after a mask write
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         blk_reg <= 1'b0;
      end else if (wr_req && wb_adr_i == `OFS_MASK) begin
         blk_reg <= 1'b1;
      end else if (cycle_en_o) begin
         blk_reg <= 1'b0;
      end
   end

   // enable/disable commands; serial and dma transfers never look at this
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gie_reg <= 1'b1;
      end else if (cmd_wr && wb_sel_i[0] && wb_dat_i[`CMD_DIS]) begin
         gie_reg <= 1'b0;
      end else if (cmd_wr && wb_sel_i[0] && wb_dat_i[`CMD_ENA]) begin
         gie_reg <= 1'b1;
      end
   end

   // ==========================================================
   // status stack, shared with loops and subroutines
   logic do_push;
   logic do_pop;

   assign do_push = take | push_i;
   assign do_pop  = ret | pop_i;

   // overflow drops the push and sets a sticky flag
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sp_reg  <= '0;
         ovf_reg <= 1'b0;
      end else if (state_reg == ST_WAKE && wake_cnt_reg == '0 && ctrl_reg[`CTL_POWER_UP_CONTEXT_RESET]) begin
         sp_reg  <= '0;
      end else if (do_push && !do_pop) begin
         if (sp_reg == 4'(`STACK_DEPTH)) begin
            ovf_reg <= 1'b1;
         end else begin
            sp_reg  <= sp_reg + 4'h1;
         end
      end else if (do_pop && !do_push && sp_reg != '0) begin
         sp_reg <= sp_reg - 4'h1;
      end
   end

   // stack memory: no reset, contents are only valid below the pointer
   always_ff @(posedge clk_i) begin
      if (do_push && !do_pop && sp_reg < 4'(`STACK_DEPTH)) begin
         stack_mem[sp_reg] <= status_i;
      end
   end

   // restored status is presented from a flop on each pop
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         status_o <= '0;
      end else if (do_pop && !do_push && sp_reg != '0) begin
         status_o <= stack_mem[sp_reg - 4'h1];
      end
   end

   // ==========================================================
   // cycle enable divider for slow idle
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= '0;
         cycle_en_o  <= 1'b0;
      end else begin
         div_cnt_reg <= (div_cnt_reg >= div_lim_reg) ? 8'h00 : div_cnt_reg + 8'h01;
         // clocks stop entirely while powered down or waking
         cycle_en_o  <= (div_cnt_reg >= div_lim_reg) && (state_reg == ST_RUN || state_reg == ST_IDLE);
      end
   end

   // ==========================================================
   // low-power sequencing
   logic [2:0] div_code;
   assign div_code = wb_dat_i[`CMD_DIV_LSB +: 3];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_RUN;
         div_lim_reg  <= '0;
         wake_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               if (cmd_wr && wb_sel_i[0] && wb_dat_i[`CMD_PD]) begin
                  state_reg <= ST_PD;
               end else if (cmd_wr && wb_sel_i[0] && wb_dat_i[`CMD_IDLE]) begin
                  state_reg   <= ST_IDLE;
                  // code 1..4 selects 16..128; anything else is plain idle
                  unique case (div_code)
                     3'd1:    div_lim_reg <= 8'd15;
                     3'd2:    div_lim_reg <= 8'd31;
                     3'd3:    div_lim_reg <= 8'd63;
                     3'd4:    div_lim_reg <= 8'd127;
                     default: div_lim_reg <= 8'd0;
                  endcase
               end
            end
            ST_IDLE: begin
               // a request is seen only on a slowed cycle, hence up to n cycles of lag
               if (want && cycle_en_o) begin
                  state_reg   <= ST_RUN;
                  div_lim_reg <= '0;
               end
            end
            ST_PD: begin
               if (act[`SRC_PWD] && !prev_reg[`SRC_PWD]) begin
                  state_reg    <= ST_WAKE;
                  wake_cnt_reg <= ctrl_reg[`CTL_OSC_STOP] ? 16'(WAKE_OSC_CYCLES - 1)
                                                          : 16'(WAKE_RUN_CYCLES - 1);
               end
            end
            ST_WAKE: begin
               if (wake_cnt_reg == '0) begin
                  state_reg <= ST_RUN;
               end else begin
                  wake_cnt_reg <= wake_cnt_reg - 16'h1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // sequencer outputs
   logic wake_done;
   assign wake_done = (state_reg == ST_WAKE) && (wake_cnt_reg == '0);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         int_take_o      <= 1'b0;
         int_vector_o    <= `VEC_RESET;
         context_clear_o <= 1'b0;
      end else begin
         int_take_o      <= take | (wake_done & ctrl_reg[`CTL_POWER_UP_CONTEXT_RESET]);
         context_clear_o <= wake_done & ctrl_reg[`CTL_POWER_UP_CONTEXT_RESET];
         if (wake_done && ctrl_reg[`CTL_POWER_UP_CONTEXT_RESET]) begin
            int_vector_o <= `VEC_RESET;
         end else if (take) begin
            int_vector_o <= (sel_idx == 4'(`SRC_PWD)) ? `VEC_PWD : {8'h00, sel_idx, 2'b00};
         end
      end
   end

   // halt and acknowledge follow the state one cycle later
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         halt_o           <= 1'b0;
         power_down_ack_o <= 1'b0;
         port1_flag_out_o <= 1'b0;
      end else begin
         halt_o           <= (state_reg != ST_RUN);
         power_down_ack_o <= (state_reg == ST_PD) || (state_reg == ST_WAKE);
         port1_flag_out_o <= p1_irq & ctrl_reg[`CTL_FLAG_OUT];
      end
   end

   // ==========================================================
   // wishbone answer, one wait state, unmapped reads give zero
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= '0;
         if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            unique case (wb_adr_i)
               `OFS_MASK: wb_dat_o <= 32'(mask_reg);
               `OFS_CTRL: wb_dat_o <= 32'(ctrl_reg);
               `OFS_STAT: wb_dat_o <= {sp_reg, gie_reg, svc_reg, 5'h00, pending};
               `OFS_INFO: wb_dat_o <= {8'h00, blk_reg, ovf_reg, port1_flag_in_i, state_reg,
                                       1'b0, halt_o, power_down_ack_o, 2'b00, int_vector_o};
               default:   wb_dat_o <= '0;
            endcase
         end
      end
   end

endmodule : dsp_interrupt_and_low_power

// ===== rtl/dsp_irq_defines.svh
/*
   Constants for the interrupt and low-power controller: register offsets,
   field positions, reset values, vectors and wake-up timing.
   Assumes 32-bit classic Wishbone, byte addresses, one word per register.
*/
`ifndef DSP_IRQ_DEFINES_SVH
`define DSP_IRQ_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_MASK      8'h00
`define OFS_CTRL      8'h04
`define OFS_FORCE     8'h08
`define OFS_CMD       8'h0c
`define OFS_STAT      8'h10
`define OFS_INFO      8'h14

// ==========================================================
// sources, index 0 is highest priority after reset
`define NSRC          11
`define NMASK         10
`define SRC_PWD       0
`define SRC_CFG_A     1
`define SRC_LVL1      2
`define SRC_LVL0      3
`define SRC_P0_TX     4
`define SRC_P0_RX     5
`define SRC_EDGE      6
`define SRC_BYTE_DMA_PORT      7
`define SRC_P1_TX     8
`define SRC_P1_RX     9
`define SRC_TIMER     10
`define VEC_RESET     14'h0000
`define VEC_PWD       14'h002c

// ==========================================================
// control register fields
`define CTL_EDGE_CFG_A 0
`define CTL_EDGE_ALT1  1
`define CTL_EDGE_ALT0  2
`define CTL_NEST       4
`define CTL_PORT1_IRQ  5
`define CTL_POWER_UP_CONTEXT_RESET       6
`define CTL_OSC_STOP   7
`define CTL_FLAG_OUT   8
`define CTL_W          9
`define CTRL_RST       9'h000
`define MASK_RST       10'h000

// force/clear: force in [10:0], clear in [26:16]
`define FC_CLR_LSB    16

// command register fields
`define CMD_ENA       0
`define CMD_DIS       1
`define CMD_IDLE      2
`define CMD_DIV_LSB   3
`define CMD_PD        6
`define CMD_RTI       7

// ==========================================================
// timing: input clock runs at half the processor cycle rate
`define INPUT_CLOCK_PER_CYC  2
`define WAKE_RUN_INPUT_CLOCK 200
`define WAKE_OSC_INPUT_CLOCK 4096
`define STACK_DEPTH    12

`endif

// ===== rtl/dsp_irq_pkg.sv
/*
   Types for the interrupt and low-power controller.
   Assumes dsp_irq_defines.svh supplies the numeric constants.
*/
package dsp_irq_pkg;
   // low-power sequencing state
   typedef enum logic [1:0] {
      ST_RUN,
      ST_IDLE,
      ST_PD,
      ST_WAKE
   } lp_state_t;

   typedef logic [3:0] src_idx_t;
endpackage : dsp_irq_pkg

// ===== verif/irq_props.sv
/* irq_props: port assertions for the interrupt and low-power controller.
   assumes one clock clk_i and asynchronous active-low nrst_i. */
`timescale 1ns/100ps
module irq_props (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        int_take_o,
   input wire logic [13:0] int_vector_o,
   input wire logic        power_down_ack_o,
   input wire logic        halt_o,
   input wire logic        cycle_en_o,
   input wire logic        context_clear_o
);
   // ==========
   // bus, vector and power-down relations
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pd_in;
      $rose(power_down_ack_o);
   endsequence
   property p_ack_resp;
      s_req |=> wb_ack_o;
   endproperty
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_vec_align;
      int_take_o |-> int_vector_o[1:0] == 2'b00 && int_vector_o <= 14'h002c;
   endproperty
   property p_pd_vec;
      power_down_ack_o && int_take_o |-> int_vector_o == 14'h0000;
   endproperty
   property p_pd_halt;
      s_pd_in |-> ##[0:1] halt_o;
   endproperty
   property p_pd_stop;
      s_pd_in |=> !cycle_en_o;
   endproperty
   property p_ctx;
      context_clear_o |-> ##[0:1] (int_vector_o == 14'h0000);
   endproperty
   property p_take_gap;
      int_take_o && int_vector_o != 14'h0000 |-> $past(cycle_en_o);
   endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("request not acked next cycle");
   a_ack_once: assert property (p_ack_once)
      else $error("ack longer than one cycle");
   a_vec_align: assert property (p_vec_align)
      else $error("vector outside table");
   a_pd_vec: assert property (p_pd_vec)
      else $error("take while powered down");
   a_pd_halt: assert property (p_pd_halt)
      else $error("power-down ack without halt");
   a_pd_stop: assert property (p_pd_stop)
      else $error("cycles run in power-down");
   a_ctx: assert property (p_ctx)
      else $error("context clear without restart vector");
   a_take_gap: assert property (p_take_gap)
      else $error("take outside processor cycle");
endmodule : irq_props
bind dsp_interrupt_and_low_power irq_props u_irq_props (.*);

// ===== verif/pin_model.sv
/* pin_model: outside devices on the active-low irq and power-down pins.
   assumes the bench sets req_i; a released pin rises to its pull-up. */
`timescale 1ns/100ps
module pin_model (
   input  wire logic       clk_i,
   input  wire logic [4:0] req_i,
   output logic      [4:0] pin_n_o
);
   // ==========
   // a level source holds its pin until the bench withdraws it
   always @(posedge clk_i) begin
      pin_n_o <= ~req_i;
   end
endmodule : pin_model

// ===== verif/testbench.sv
/* testbench: directed checks of the irq and low-power controller.
   assumes pin_model on the pins and a classic Wishbone master here. */
`timescale 1ns/100ps
`include "dsp_irq_defines.svh"
module testbench;
   localparam int WR = 20;
   localparam int SRC[6] = '{4, 5, 7, 8, 9, 10};
   logic clk_i = 1'b0, nrst_i = 1'b0, ret_i = 1'b0, fin = 1'b0, fout;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [5:0] ev = 6'h00;
   logic [4:0] req = 5'h00, pin_n;
   logic [15:0] status_i = 16'h0000, status_o;
   logic [13:0] int_vector_o;
   logic int_take_o, halt_o, cycle_en_o, context_clear_o, power_down_ack_o;
   int err_count = 0, checks = 0, n, seen;
   dsp_interrupt_and_low_power #(.WAKE_RUN_CYCLES(WR), .WAKE_OSC_CYCLES(40)) u_dsp_interrupt_and_low_power (.*,
      .ext_irq_cfg_a_n_i(pin_n[0]), .ext_level_irq_1_n_i(pin_n[1]), .ext_level_irq_0_n_i(pin_n[2]),
      .ext_edge_irq_n_i(pin_n[3]), .power_down_request_pin_n_i(pin_n[4]), .port1_flag_out_o(fout),
      .port1_alt_irq_0_n_i(1'b1), .port1_alt_irq_1_n_i(1'b1), .port1_flag_in_i(fin),
      .port0_tx_i(ev[0]), .port0_rx_i(ev[1]), .byte_dma_port_i(ev[2]), .port1_tx_i(ev[3]),
      .port1_rx_i(ev[4]), .timer_i(ev[5]), .push_i(1'b0), .pop_i(1'b0));
   pin_model u_pin_model (.clk_i(clk_i), .req_i(req), .pin_n_o(pin_n));
   // ==========
   // clock, shared tasks
   always #2.5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   // bounded wait, so a missing take shows as a flag mismatch
   task automatic take(input logic [13:0] v);
      n = 0;
      while (int_take_o !== 1'b1 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      chk({int_take_o, int_vector_o}, {1'b1, v});
   endtask : take
   // settle released pins first so a stale level is not taken again
   task automatic give_ret;
      repeat (3) @(posedge clk_i);
      ret_i <= 1'b1;
      @(posedge clk_i);
      ret_i <= 1'b0;
      // one edge only, so the take pulse of a waiting request is not missed
      @(posedge clk_i);
   endtask : give_ret
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // ==========
   // scenarios
   task automatic t_reset;
      bus(1'b0, `OFS_STAT, 32'h0);
      chk(rd[27], 1'b1);
      bus(1'b0, `OFS_MASK, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `OFS_FORCE, 32'h0);
      chk(rd, 32'h0);
      fin <= 1'b1;
      bus(1'b0, `OFS_INFO, 32'h0);
      chk(rd[21], 1'b1);
      bus(1'b1, `OFS_CTRL, 32'h120);
      chk(fout, 1'b1);
      bus(1'b1, `OFS_CTRL, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_events;
      bus(1'b1, `OFS_MASK, 32'h3ff);
      for (int k = 0; k < 6; k++) begin
         status_i <= 16'h00a0 + 16'(k);
         ev[k] <= 1'b1;
         @(posedge clk_i);
         ev[k] <= 1'b0;
         take(14'(4 * SRC[k]));
         give_ret();
         chk(status_o, 16'h00a0 + 16'(k));
      end
      $display("event test done");
   endtask : t_events
   task automatic t_prio;
      req <= 5'h07;
      take(14'h0004);
      for (int k = 1; k < 4; k++) begin
         req <= req & ~(5'h01 << (k - 1));
         give_ret();
         if (k < 3)
            take(14'(4 * (k + 1)));
      end
      $display("priority test done");
   endtask : t_prio
   task automatic t_gie;
      bus(1'b1, `OFS_CMD, 32'h2);
      bus(1'b1, `OFS_FORCE, 32'h40);
      seen = 0;
      repeat (20) begin
         @(posedge clk_i);
         seen += int'(int_take_o === 1'b1);
      end
      chk(seen, 0);
      bus(1'b1, `OFS_CMD, 32'h1);
      take(14'h0018);
      give_ret();
      bus(1'b1, `OFS_CMD, 32'h0c);
      chk(halt_o, 1'b1);
      bus(1'b1, `OFS_FORCE, 32'h40);
      take(14'h0018);
      give_ret();
      $display("enable test done");
   endtask : t_gie
   task automatic t_pd;
      req <= 5'h10;
      @(posedge clk_i);
      req <= 5'h00;
      take(14'h002c);
      give_ret();
      bus(1'b1, `OFS_CTRL, 32'h40);
      bus(1'b1, `OFS_CMD, 32'h40);
      repeat (3) @(posedge clk_i);
      chk(power_down_ack_o, 1'b1);
      req <= 5'h10;
      n = 0;
      seen = 0;
      while (power_down_ack_o === 1'b1 && n < 200) begin
         @(posedge clk_i);
         req <= 5'h00;
         n++;
         seen |= int'(context_clear_o === 1'b1);
      end
      chk(n >= WR && n <= WR + 6, 1'b1);
      repeat (3) begin
         @(posedge clk_i);
         seen |= int'(context_clear_o === 1'b1);
      end
      chk(seen, 1);
      bus(1'b1, `OFS_CMD, 32'h40);
      repeat (3) @(posedge clk_i);
      chk(power_down_ack_o, 1'b1);
      nrst_i <= 1'b0;
      @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(power_down_ack_o, 1'b0);
      $display("power-down test done");
   endtask : t_pd
   initial begin
      #(5 * 20000);
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_reset();
      t_events();
      t_prio();
      t_gie();
      t_pd();
      end_of_test();
   end
endmodule : testbench
